/* include/flash_port_pkg.sv */
package flash_port_pkg;

  // array geometry: 8M byte-wide locations
  localparam int ADDR_W = 23;
  localparam int SECTOR_LSB = 16;
  localparam int SUBSEC_LSB = 12;
  localparam int SECTORS = 128;
  localparam int SUBSEC_PER_SECTOR = 16;
  localparam int SUBSECTORS = SECTORS * SUBSEC_PER_SECTOR;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [6:0] OTP_BYTES = 7'h40;
  localparam logic [6:0] OTP_LOCK_ADDR = 7'h40;
  localparam int OTP_LOCK_BIT = 0;
  localparam int FIFO_DEPTH = 8;

  // serial framing counts, in link clock edges
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [4:0] DUMMY_LAST = 5'h07;

  // synchroniser reset: {do, di, hold_n, cs_n, sclk}
  localparam logic [4:0] PIN_RST = 5'h06;

  // instruction codes
  localparam logic [7:0] read_cmd = 8'h03;
  localparam logic [7:0] dual_output_read_cmd = 8'h3B;
  localparam logic [7:0] otp_read_cmd = 8'h4B;
  localparam logic [7:0] page_program_cmd = 8'h02;
  localparam logic [7:0] dual_input_program_cmd = 8'hA2;
  localparam logic [7:0] otp_program_cmd = 8'h42;
  localparam logic [7:0] subsector_erase_cmd = 8'h20;
  localparam logic [7:0] sector_erase_cmd = 8'hD8;
  localparam logic [7:0] bulk_erase_cmd = 8'hC7;

  typedef enum logic [1:0] {
    ERASE_SUBSEC,
    ERASE_SECTOR,
    ERASE_BULK
  } erase_scope_t;

  typedef struct packed {
    logic otp;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } prog_word_t;

  typedef struct packed {
    erase_scope_t scope;
    logic [ADDR_W-1:0] addr;
  } erase_req_t;

  typedef struct packed {
    logic otp;
    logic [ADDR_W-1:0] addr;
  } rd_req_t;

endpackage

/* design/sync_fifo.sv */
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two: pointers wrap by overflow
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic wr_fire;
  logic rd_fire;

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign wr_fire = in_valid && in_ready;
  assign rd_fire = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (wr_fire) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_fire) begin
        wr_q <= wr_q + 1'b1;
      end
      if (rd_fire) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(wr_fire) - (AW+1)'(rd_fire);
    end
  end

endmodule

/* design/dual_io_serial_flash_port.sv */
// Operation
// R1: single output bits change on falling clock
// R2: instruction, address, data sampled on rising clock
// R3: master holds data-in stable at rising edge
// R4: dual read drives data-in pin on falling
// R5: dual read puts two bits per clock
// R6: dual program samples data-out pin on rising
// R7: master drives two program bits per clock
// R8: every address selects one byte
// R9: page program takes one to 256 bytes
// R10: 128 sectors of 16 subsectors each
// R11: erase subsector, sector, or whole array
// R12: sector protection merges volatile and non-volatile
// R13: 64-byte OTP area via own instructions
// R14: OTP lock is permanent, blocks programming; here a device reset clears the lock
// R15: deselected: outputs released, standby when idle
// R16: falling chip select needed before instructions; here a cs_n held low through reset counts as a fall
// R17: hold pauses link, floats output, ignores inputs
// R18: both clock polarities behave the same
// R19: instruction, address msb first, data, one frame
// R20: data-in pin driven only in dual read data
`timescale 1ns/1ps
module dual_io_serial_flash_port (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic serial_data_in_pin,
  output logic serial_data_in_pin_drive,
  output logic serial_data_in_pin_en,
  input wire logic serial_data_out_pin,
  output logic serial_data_out_pin_drive,
  output logic serial_data_out_pin_en,
  output flash_port_pkg::rd_req_t rd_req,
  output logic rd_req_valid,
  input wire logic [7:0] rd_data,
  output flash_port_pkg::prog_word_t prog_word,
  output logic prog_valid,
  input wire logic prog_ready,
  output flash_port_pkg::erase_req_t erase_req,
  output logic erase_valid,
  input wire logic [flash_port_pkg::SECTORS-1:0] sector_nv_protect,
  input wire logic [flash_port_pkg::SECTORS-1:0] sector_vol_lock,
  input wire logic busy,
  output logic standby,
  output logic otp_locked,
  output logic overrun
);

  typedef enum {PH_CMD, PH_ADDR, PH_DUMMY, PH_RDATA, PH_WDATA,
    PH_IGNORE} phase_t;

  logic [4:0] pin_m_q;
  logic [4:0] pin_s_q;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic armed_q;
  phase_t st_q;
  phase_t st_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [7:0] cmd_q;
  logic [7:0] sh_q;
  logic [23:0] addr_q;
  logic addr_done_q;
  logic [8:0] pcount_q;
  logic [22:0] rd_addr_q;
  logic rd_otp_q;
  logic rd_req_q;
  logic rd_ack_q;
  logic [7:0] nxt_q;
  logic [7:0] tx_q;
  logic [2:0] txcnt_q;
  logic started_q;
  logic so_drv_q;
  logic so_en_q;
  logic si_drv_q;
  logic si_en_q;
  logic otp_lock_q;
  logic overrun_q;
  logic standby_q;
  flash_port_pkg::erase_req_t erase_q;
  logic erase_valid_q;

  // synchronised pins; only the second stage is looked at
  wire sclk_s = pin_s_q[0];
  wire cs_s = pin_s_q[1];
  wire hold_s = pin_s_q[2];
  wire di_s = pin_s_q[3];
  wire do_s = pin_s_q[4];

  wire hold_act = !hold_s && !cs_s; // R17
  wire live = !cs_s && !hold_act && armed_q; // R16
  wire rise = live && sclk_s && !sclk_prev_q; // R2 R18
  wire fall = live && !sclk_s && sclk_prev_q; // R1 R18
  wire cs_fall = cs_prev_q && !cs_s;
  wire cs_rise = !cs_prev_q && cs_s;

  // instruction decode
  wire [7:0] cmd_byte = {sh_q[6:0], di_s}; // R3
  wire is_read = cmd_q == flash_port_pkg::read_cmd;
  wire is_dread = cmd_q == flash_port_pkg::dual_output_read_cmd;
  wire is_oread = cmd_q == flash_port_pkg::otp_read_cmd;
  wire is_pp = cmd_q == flash_port_pkg::page_program_cmd;
  wire is_dprog = cmd_q == flash_port_pkg::dual_input_program_cmd;
  wire is_oprog = cmd_q == flash_port_pkg::otp_program_cmd;
  wire is_sse = cmd_q == flash_port_pkg::subsector_erase_cmd;
  wire is_se = cmd_q == flash_port_pkg::sector_erase_cmd;
  wire is_be = cmd_q == flash_port_pkg::bulk_erase_cmd;
  wire rd_cmd = is_read || is_dread || is_oread;
  wire wr_cmd = is_pp || is_dprog || is_oprog;
  wire byte_has_addr =
    cmd_byte == flash_port_pkg::read_cmd ||
    cmd_byte == flash_port_pkg::dual_output_read_cmd ||
    cmd_byte == flash_port_pkg::otp_read_cmd ||
    cmd_byte == flash_port_pkg::page_program_cmd ||
    cmd_byte == flash_port_pkg::dual_input_program_cmd ||
    cmd_byte == flash_port_pkg::otp_program_cmd ||
    cmd_byte == flash_port_pkg::subsector_erase_cmd ||
    cmd_byte == flash_port_pkg::sector_erase_cmd;

  // address msb first; top bit of the 24 sent is beyond the array
  wire [22:0] full_addr = {addr_q[21:0], di_s}; // R19 R8
  wire [22:0] byte_addr = addr_q[22:0];
  wire cmd_last = cnt_q == flash_port_pkg::CMD_LAST;
  wire addr_last = cnt_q == flash_port_pkg::ADDR_LAST;
  wire dummy_last = cnt_q == flash_port_pkg::DUMMY_LAST;
  wire rd_start = rise && st_q == PH_ADDR && addr_last && rd_cmd;

  // program data path
  wire [7:0] wbyte = is_dprog ? {sh_q[5:0], do_s, di_s} : cmd_byte; // R6
  wire wbyte_done = cnt_q[2:0] == (is_dprog ? 3'h6 : 3'h7);
  wire [flash_port_pkg::SECTORS-1:0] prot_vec =
    sector_nv_protect | sector_vol_lock; // R12
  wire sector_prot = prot_vec[byte_addr[22:flash_port_pkg::SECTOR_LSB]];
  wire any_prot = |prot_vec;
  wire [6:0] otp_addr = byte_addr[6:0];
  wire otp_ok = !otp_lock_q && otp_addr < flash_port_pkg::OTP_BYTES;
  wire room = pcount_q < flash_port_pkg::PAGE_BYTES; // R9
  wire take = rise && st_q == PH_WDATA && wbyte_done;
  wire push_ok = room && (is_oprog ? otp_ok : !sector_prot); // R13 R14
  wire push = take && push_ok;
  wire lock_hit = take && is_oprog && !otp_lock_q &&
    otp_addr == flash_port_pkg::OTP_LOCK_ADDR &&
    !wbyte[flash_port_pkg::OTP_LOCK_BIT]; // R14
  wire fifo_in_ready;
  flash_port_pkg::prog_word_t fifo_in;
  assign fifo_in = '{otp: is_oprog, addr: byte_addr, data: wbyte};

  // read data path
  wire load = fall && st_q == PH_RDATA && txcnt_q == 3'h0;
  wire [7:0] tx_src = load ? nxt_q : tx_q;
  wire [7:0] tx_next = is_dread ? {tx_src[5:0], 2'b00} :
    {tx_src[6:0], 1'b0};
  wire [2:0] txcnt_next = load ? (is_dread ? 3'h3 : 3'h7) :
    txcnt_q - 3'h1;
  wire drive_ok = !cs_s && !hold_act && st_q == PH_RDATA &&
    (started_q || fall);

  // erase is taken only when the frame closes cleanly
  wire erase_go = cs_rise && st_q == PH_IGNORE &&
    ((is_be && !any_prot) ||
    ((is_sse || is_se) && addr_done_q && !sector_prot)); // R11 R19
  wire [22:0] sse_addr = (byte_addr >> flash_port_pkg::SUBSEC_LSB)
    << flash_port_pkg::SUBSEC_LSB; // R10
  wire [22:0] se_addr = (byte_addr >> flash_port_pkg::SECTOR_LSB)
    << flash_port_pkg::SECTOR_LSB;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_m_q <= flash_port_pkg::PIN_RST;
      pin_s_q <= flash_port_pkg::PIN_RST;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      pin_m_q <= {serial_data_out_pin, serial_data_in_pin, hold_n, cs_n,
        sclk};
      pin_s_q <= pin_m_q;
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_s;
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 5'h01;
    unique case (st_q)
      PH_CMD: begin
        if (cmd_last) begin
          cnt_d = '0;
          st_d = byte_has_addr ? PH_ADDR : PH_IGNORE;
        end
      end
      PH_ADDR: begin
        if (addr_last) begin
          cnt_d = '0;
          if (is_read) begin
            st_d = PH_RDATA;
          end else if (rd_cmd) begin
            st_d = PH_DUMMY;
          end else if (wr_cmd) begin
            st_d = PH_WDATA;
          end else begin
            st_d = PH_IGNORE;
          end
        end
      end
      PH_DUMMY: begin
        if (dummy_last) begin
          cnt_d = '0;
          st_d = PH_RDATA;
        end
      end
      PH_WDATA: begin
        cnt_d = cnt_q + (is_dprog ? 5'h02 : 5'h01); // R6
      end
      PH_RDATA, PH_IGNORE: begin
        cnt_d = cnt_q;
      end
    endcase
  end

  // a frame always restarts at the instruction byte
  always_ff @(posedge mclk) begin
    if (!resetn || cs_s) begin
      st_q <= PH_CMD;
      cnt_q <= '0;
      addr_done_q <= 1'b0;
      pcount_q <= '0;
    end else if (rise) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (st_q == PH_ADDR && addr_last) begin
        addr_done_q <= 1'b1;
      end
      if (take && room) begin
        pcount_q <= pcount_q + 9'h001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cmd_q <= '0;
      sh_q <= '0;
      addr_q <= '0;
    end else if (rise) begin
      sh_q <= is_dprog && st_q == PH_WDATA ? wbyte : cmd_byte; // R2
      if (st_q == PH_CMD && cmd_last) begin
        cmd_q <= cmd_byte;
      end
      if (st_q == PH_ADDR) begin
        addr_q <= {addr_q[22:0], di_s};
      end else if (take) begin
        // program address wraps inside its page
        addr_q[7:0] <= addr_q[7:0] + 8'h01; // R9
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_req_q <= 1'b0;
      rd_ack_q <= 1'b0;
      rd_addr_q <= '0;
      rd_otp_q <= 1'b0;
      nxt_q <= '0;
    end else begin
      rd_req_q <= rd_start || load;
      rd_ack_q <= rd_req_q;
      if (rd_start) begin
        rd_addr_q <= full_addr;
        rd_otp_q <= is_oread; // R13
      end else if (load) begin
        rd_addr_q <= rd_addr_q + 23'h000001;
      end
      if (rd_ack_q) begin
        nxt_q <= rd_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || cs_s) begin
      tx_q <= '0;
      txcnt_q <= '0;
      started_q <= 1'b0;
    end else if (fall && st_q == PH_RDATA) begin
      tx_q <= tx_next;
      txcnt_q <= txcnt_next;
      started_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      so_drv_q <= 1'b0;
      si_drv_q <= 1'b0;
      so_en_q <= 1'b0;
      si_en_q <= 1'b0;
    end else begin
      if (fall && st_q == PH_RDATA) begin
        so_drv_q <= tx_src[7]; // R1 R5
        si_drv_q <= is_dread && tx_src[6]; // R4 R5
      end
      so_en_q <= drive_ok; // R15 R17
      si_en_q <= drive_ok && is_dread; // R4 R20
    end
  end

  // lock survives every frame; only a device reset clears it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      armed_q <= 1'b0;
      otp_lock_q <= 1'b0;
      overrun_q <= 1'b0;
      standby_q <= 1'b0;
      erase_valid_q <= 1'b0;
      erase_q <= '{scope: flash_port_pkg::ERASE_BULK, addr: '0};
    end else begin
      armed_q <= armed_q || cs_fall; // R16
      otp_lock_q <= otp_lock_q || lock_hit; // R14
      overrun_q <= (push && !fifo_in_ready) || (overrun_q && !cs_fall);
      standby_q <= cs_s && !busy; // R15
      erase_valid_q <= erase_go;
      if (erase_go) begin
        if (is_sse) begin
          erase_q <= '{scope: flash_port_pkg::ERASE_SUBSEC, addr: sse_addr};
        end else if (is_se) begin
          erase_q <= '{scope: flash_port_pkg::ERASE_SECTOR, addr: se_addr};
        end else begin
          erase_q <= '{scope: flash_port_pkg::ERASE_BULK, addr: '0};
        end
      end
    end
  end

  // the link cannot stall; a full buffer drops the byte and flags it
  sync_fifo #(
    .WIDTH($bits(flash_port_pkg::prog_word_t)),
    .DEPTH(flash_port_pkg::FIFO_DEPTH)
  ) u_prog_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_data(fifo_in),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(prog_word),
    .out_valid(prog_valid),
    .out_ready(prog_ready)
  );

  assign serial_data_out_pin_drive = so_drv_q;
  assign serial_data_out_pin_en = so_en_q;
  assign serial_data_in_pin_drive = si_drv_q;
  assign serial_data_in_pin_en = si_en_q;
  assign rd_req = '{otp: rd_otp_q, addr: rd_addr_q};
  assign rd_req_valid = rd_req_q;
  assign erase_req = erase_q;
  assign erase_valid = erase_valid_q;
  assign standby = standby_q;
  assign otp_locked = otp_lock_q;
  assign overrun = overrun_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  property p_out_on_fall;
    $changed(so_drv_q) |-> $past(fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) // R1
    else $error("data-out bit changed without a falling clock");

  property p_in_on_rise;
    $changed(sh_q) |-> $past(rise);
  endproperty
  a_in_on_rise: assert property (p_in_on_rise) // R2
    else $error("input shift moved without a rising clock");

  property p_dual_drive;
    si_en_q |-> $past(is_dread && st_q == PH_RDATA && !cs_s);
  endproperty
  a_dual_drive: assert property (p_dual_drive) // R20
    else $error("data-in pin driven outside dual read data");

  property p_dual_step;
    rise && st_q == PH_WDATA && is_dprog |=> cnt_q == $past(cnt_q) + 5'h02;
  endproperty
  a_dual_step: assert property (p_dual_step) // R6
    else $error("dual program did not take two bits");

  property p_page_limit;
    push |-> pcount_q < flash_port_pkg::PAGE_BYTES;
  endproperty
  a_page_limit: assert property (p_page_limit) // R9
    else $error("more than a page of bytes accepted");

  property p_erase_align;
    erase_valid_q && erase_q.scope == flash_port_pkg::ERASE_SUBSEC
      |-> erase_q.addr[11:0] == 12'h000;
  endproperty
  a_erase_align: assert property (p_erase_align) // R11
    else $error("subsector erase address not aligned");

  property p_protect;
    push && !is_oprog |-> !sector_prot;
  endproperty
  a_protect: assert property (p_protect) // R12
    else $error("byte accepted for a protected sector");

  property p_otp_sticky;
    otp_lock_q |=> otp_lock_q ##1 otp_lock_q;
  endproperty
  a_otp_sticky: assert property (p_otp_sticky) // R14
    else $error("otp lock was released");

  property p_otp_blocked;
    push && is_oprog |-> !otp_lock_q && otp_addr < flash_port_pkg::OTP_BYTES;
  endproperty
  a_otp_blocked: assert property (p_otp_blocked) // R13
    else $error("otp byte accepted while locked or out of range");

  property p_deselect;
    cs_s |=> !so_en_q && !si_en_q;
  endproperty
  a_deselect: assert property (p_deselect) // R15
    else $error("pin driven while deselected");

  property p_hold;
    hold_act |=> !so_en_q && !si_en_q;
  endproperty
  a_hold: assert property (p_hold) // R17
    else $error("pin driven during hold");

  property p_erase_frame;
    erase_valid_q |-> $past(cs_rise);
  endproperty
  a_erase_frame: assert property (p_erase_frame) // R19
    else $error("erase issued outside frame end");

  c_single_read: cover property (load && is_read);
  c_dual_read: cover property (load && is_dread);
  c_dual_prog: cover property (push && is_dprog);
  c_otp_lock: cover property ($rose(otp_lock_q));

endmodule

/* testbench/spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
  output logic sclk,
  output logic cs_n,
  output logic hold_n,
  output logic di_pin,
  output logic do_pin,
  input wire logic di_drive,
  input wire logic di_en,
  input wire logic do_drive,
  input wire logic do_en
);
  logic [1:0] md;
  logic cpol;
  // a released line shows the inverse of its last level, never a stale one
  assign di_pin = di_en ? di_drive : md[0];
  assign do_pin = do_en ? do_drive : md[1];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    md = 2'b00;
    cpol = 1'b0;
  end
  // one link clock: fall, drive, rise, sample late in the high phase
  task automatic cyc(input logic [1:0] d, input logic [1:0] e,
                     output logic [1:0] s);
    if (sclk) sclk = 1'b0;
    md[0] = e[0] ? d[0] : ~di_pin;
    md[1] = e[1] ? d[1] : ~do_pin;
    #160;
    sclk = 1'b1;
    #160;
    s = {do_pin, di_pin};
  endtask
  // mode 0 send, 1 receive, 2 dual send, 3 dual receive
  task automatic xfer(input logic [7:0] o, input int mode,
                      output logic [7:0] r);
    logic [1:0] s;
    int n;
    n = (mode >= 2) ? 4 : 8;
    r = 8'h00;
    for (int k = 0; k < n; k++) begin
      case (mode)
        0: cyc({1'b0, o[7-k]}, 2'b01, s);
        1: cyc(2'b00, 2'b00, s);
        2: cyc(o[7-2*k -: 2], 2'b11, s);
        default: cyc(2'b00, 2'b00, s);
      endcase
      r = (mode == 3) ? {r[5:0], s} : {r[6:0], s[1]};
    end
  endtask
  task automatic send_addr(input logic [23:0] a);
    logic [7:0] r;
    for (int i = 2; i >= 0; i--) begin
      xfer(a[8*i +: 8], 0, r);
    end
  endtask
  task automatic begin_frame(input logic pol);
    cpol = pol;
    sclk = pol;
    #200;
    cs_n = 1'b0;
    #160;
  endtask
  task automatic end_frame();
    if (!cpol) sclk = 1'b0;
    #160;
    cs_n = 1'b1;
    #400;
  endtask
endmodule

/* testbench/dual_io_serial_flash_port_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module dual_io_serial_flash_port_bench;
  logic mclk, resetn, prog_ready, busy, di_seen;
  logic sclk, cs_n, hold_n, di_pin, do_pin, di_drive, di_en, do_drive, do_en;
  logic rd_req_valid, prog_valid, erase_valid, standby, otp_locked, overrun;
  logic [7:0] rd_data;
  logic [127:0] nv_protect, vol_lock;
  flash_port_pkg::rd_req_t rd_req;
  flash_port_pkg::prog_word_t prog_word;
  flash_port_pkg::erase_req_t erase_req, last_erase;
  int n_errors, n_checks, n_erase, cycles;

  function automatic logic [7:0] mem_byte(input logic otp,
                                          input logic [22:0] a);
    return a[7:0] ^ a[15:8] ^ {1'b0, a[22:16]} ^ {otp, 7'h2A};
  endfunction
  // combinational array answer covers any fixed sampling delay
  assign rd_data = mem_byte(rd_req.otp, rd_req.addr);

  spi_master_model m (.sclk(sclk), .cs_n(cs_n), .hold_n(hold_n),
    .di_pin(di_pin), .do_pin(do_pin), .di_drive(di_drive), .di_en(di_en),
    .do_drive(do_drive), .do_en(do_en));
  dual_io_serial_flash_port dut (.mclk(mclk), .resetn(resetn), .sclk(sclk),
    .cs_n(cs_n), .hold_n(hold_n), .serial_data_in_pin(di_pin),
    .serial_data_in_pin_drive(di_drive), .serial_data_in_pin_en(di_en),
    .serial_data_out_pin(do_pin), .serial_data_out_pin_drive(do_drive),
    .serial_data_out_pin_en(do_en), .rd_req(rd_req),
    .rd_req_valid(rd_req_valid), .rd_data(rd_data), .prog_word(prog_word),
    .prog_valid(prog_valid), .prog_ready(prog_ready), .erase_req(erase_req),
    .erase_valid(erase_valid), .sector_nv_protect(nv_protect),
    .sector_vol_lock(vol_lock), .busy(busy), .standby(standby),
    .otp_locked(otp_locked), .overrun(overrun));

  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    if (erase_valid === 1'b1) begin
      n_erase++;
      last_erase = erase_req;
    end
    if (di_en === 1'b1) di_seen = 1'b1;
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmd_frame(input logic [7:0] c, input logic [23:0] a);
    logic [7:0] r;
    m.begin_frame(1'b0);
    m.xfer(c, 0, r);
    if (c != flash_port_pkg::bulk_erase_cmd) m.send_addr(a);
  endtask
  task automatic drain(input int n, input logic [22:0] a,
                       input logic [7:0] d, input logic otp);
    flash_port_pkg::prog_word_t w;
    for (int i = 0; i < n; i++) begin
      w.otp = otp;
      w.addr = {a[22:8], a[7:0] + 8'(i)};
      w.data = d + 8'(i);
      `CHK(prog_valid, 1'b1)
      `CHK(prog_word, w)
      @(posedge mclk) #1 prog_ready = 1'b1;
      @(posedge mclk) #1 prog_ready = 1'b0;
    end
    `CHK(prog_valid, 1'b0)
  endtask
  task automatic t_read(input logic pol);
    logic [7:0] r;
    m.begin_frame(pol);
    m.xfer(flash_port_pkg::read_cmd, 0, r);
    m.send_addr(24'h012345);
    m.xfer(8'h00, 1, r);
    `CHK(r, mem_byte(1'b0, 23'h012345))
    m.xfer(8'h00, 1, r);
    `CHK(r, mem_byte(1'b0, 23'h012346))
    m.hold_n = 1'b0;
    #400;
    `CHK(do_en, 1'b0)
    m.hold_n = 1'b1;
    m.end_frame();
    `CHK(do_en, 1'b0)
    @(posedge mclk) #1 busy = 1'b1;
    repeat (3) @(posedge mclk);
    #1 `CHK(standby, 1'b0)
    busy = 1'b0;
    repeat (3) @(posedge mclk);
    #1 `CHK(standby, 1'b1)
  endtask
  task automatic t_dual_read();
    logic [7:0] r;
    cmd_frame(flash_port_pkg::dual_output_read_cmd, 24'h7FFFFF);
    di_seen = 1'b0;
    m.xfer(8'h00, 1, r);
    `CHK(di_seen, 1'b0)
    m.xfer(8'h00, 3, r);
    `CHK(r, mem_byte(1'b0, 23'h7FFFFF))
    m.xfer(8'h00, 3, r);
    `CHK(r, mem_byte(1'b0, 23'h000000))
    m.end_frame();
    `CHK(di_seen, 1'b1)
    `CHK(di_en, 1'b0)
  endtask
  task automatic t_programs();
    logic [7:0] r;
    cmd_frame(flash_port_pkg::page_program_cmd, 24'h0000FE);
    for (int i = 0; i < 10; i++) m.xfer(8'hA0 + 8'(i), 0, r);
    m.end_frame();
    `CHK(overrun, 1'b1)
    drain(8, 23'h0000FE, 8'hA0, 1'b0);
    cmd_frame(flash_port_pkg::dual_input_program_cmd, 24'h100010);
    m.xfer(8'h96, 2, r);
    m.xfer(8'h97, 2, r);
    m.end_frame();
    drain(2, 23'h100010, 8'h96, 1'b0);
    vol_lock[16] = 1'b1;
    cmd_frame(flash_port_pkg::dual_input_program_cmd, 24'h100010);
    m.xfer(8'h96, 2, r);
    m.end_frame();
    `CHK(prog_valid, 1'b0)
    vol_lock[16] = 1'b0;
  endtask
  task automatic t_erase();
    n_erase = 0;
    cmd_frame(flash_port_pkg::subsector_erase_cmd, 24'h123456);
    m.end_frame();
    `CHK(last_erase, {flash_port_pkg::ERASE_SUBSEC, 23'h123000})
    cmd_frame(flash_port_pkg::sector_erase_cmd, 24'h123456);
    m.end_frame();
    `CHK(last_erase, {flash_port_pkg::ERASE_SECTOR, 23'h120000})
    cmd_frame(flash_port_pkg::bulk_erase_cmd, 24'h000000);
    m.end_frame();
    `CHK(last_erase.scope, flash_port_pkg::ERASE_BULK)
    `CHK(n_erase, 3)
    nv_protect[18] = 1'b1;
    cmd_frame(flash_port_pkg::sector_erase_cmd, 24'h123456);
    m.end_frame();
    cmd_frame(flash_port_pkg::bulk_erase_cmd, 24'h000000);
    m.end_frame();
    `CHK(n_erase, 3)
    nv_protect[18] = 1'b0;
  endtask
  task automatic t_otp();
    logic [7:0] r;
    cmd_frame(flash_port_pkg::otp_program_cmd, 24'h000005);
    m.xfer(8'h3C, 0, r);
    m.end_frame();
    drain(1, 23'h000005, 8'h3C, 1'b1);
    cmd_frame(flash_port_pkg::otp_read_cmd, 24'h000005);
    m.xfer(8'h00, 1, r);
    m.xfer(8'h00, 1, r);
    m.end_frame();
    `CHK(r, mem_byte(1'b1, 23'h000005))
    // lock write to 0x40 is outside the OTP range and never reaches the stream; ready is held high anyway
    prog_ready = 1'b1;
    cmd_frame(flash_port_pkg::otp_program_cmd, 24'h000040);
    m.xfer(8'hFE, 0, r);
    m.end_frame();
    prog_ready = 1'b0;
    `CHK(otp_locked, 1'b1)
    cmd_frame(flash_port_pkg::otp_program_cmd, 24'h000005);
    m.xfer(8'h00, 0, r);
    m.end_frame();
    `CHK(prog_valid, 1'b0)
    `CHK(otp_locked, 1'b1)
  endtask

  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    prog_ready = 1'b0;
    busy = 1'b0;
    nv_protect = '0;
    vol_lock = '0;
    di_seen = 1'b0;
    n_errors = 0;
    n_checks = 0;
    n_erase = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge mclk);
    // keep every pin change off the sampling edge
    #1;
    t_read(1'b0);
    t_read(1'b1);
    t_dual_read();
    t_programs();
    t_erase();
    t_otp();
    finish_test();
  end
endmodule
